// ---- design/tps_pkg.sv ----
// Constants and types shared by the tape port selector files
package tps_pkg;

  // ****************************************************************
  // Bus and field layout
  // ****************************************************************
  localparam int ADDR_W      = 17;  // Bit 16 is the control-mode bit
  localparam int WORD_W      = 24;
  localparam int MODE_BIT    = 16;
  localparam int UNIT_HI     = 15;
  localparam int UNIT_LO     = 11;
  localparam int UNIT_W      = 5;
  localparam int TARGET_BIT  = 10;
  localparam int INDEX_HI    = 9;
  localparam int INDEX_W     = 10;
  localparam int NUM_CTRL    = 16;
  localparam int CTRL_IDX_W  = 4;
  localparam int STORE_W     = 1 + 2 * WORD_W;  // Write flag, address, data
  localparam int FIFO_DEPTH  = 32;

  // ****************************************************************
  // Register indexes and reset values
  // ****************************************************************
  localparam logic [INDEX_W-1:0] REG_COMMAND  = 10'h000;  // Normal mode
  localparam logic [INDEX_W-1:0] REG_ADDRESS  = 10'h001;  // Normal mode
  localparam logic [INDEX_W-1:0] CREG_ASSIGN  = 10'h000;  // Control mode
  localparam logic [INDEX_W-1:0] CREG_STATUS  = 10'h001;
  localparam logic [INDEX_W-1:0] CREG_COMMAND = 10'h002;
  localparam logic [INDEX_W-1:0] CREG_ADDRESS = 10'h003;
  localparam logic [NUM_CTRL-1:0] ASSIGN_RESET = 16'h0000;
  localparam logic [WORD_W-1:0]   WORD_RESET   = 24'h000000;
  localparam logic [UNIT_W-1:0]   UNIT_DEFAULT = 5'h02;  // Arbitrary value

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_SCAN,
    ST_GRANT,
    ST_ACCESS
  } tps_state_type;

endpackage : tps_pkg

// ---- design/tps_fifo.sv ----
// Store-word FIFO between enabled controller and bus interface
`timescale 1ns/100ps
module tps_fifo #(
  parameter int WIDTH = 49,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,     // System clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word in
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Drain side takes word
  output logic      [WIDTH-1:0] out_data,  // Word out
  output logic                  empty      // No word held
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Extra pointer bit tells full from empty
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[PW-1:0]];

  // Storage has no reset, only pointers do
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // tps_fifo

// ---- design/tps_rr_arbiter.sv ----
// Round-robin pick of next requesting controller after the last grant
`timescale 1ns/100ps
module tps_rr_arbiter (
  input  wire logic [tps_pkg::NUM_CTRL-1:0]   req,   // Eligible requests
  input  wire logic [tps_pkg::CTRL_IDX_W-1:0] last,  // Last granted index
  output logic                                found, // Some request present
  output logic      [tps_pkg::CTRL_IDX_W-1:0] pick   // Chosen index
);
  logic [tps_pkg::NUM_CTRL-1:0]   hit;
  logic [tps_pkg::CTRL_IDX_W-1:0] cand [tps_pkg::NUM_CTRL];

  // Candidate i is the (i+1)-th controller after the last one served
  for (genvar i = 0; i < tps_pkg::NUM_CTRL; i++) begin : g_cand
    assign cand[i] = last + tps_pkg::CTRL_IDX_W'(i + 1);
    assign hit[i]  = req[cand[i]];
  end

  // Nearest candidate wins, so nobody is starved
  always_comb begin
    pick = last;
    for (int i = tps_pkg::NUM_CTRL - 1; i >= 0; i--) begin
      if (hit[i]) pick = cand[i];
    end
  end
  assign found = |req;
endmodule // tps_rr_arbiter

// ---- design/tps_selector.sv ----
// Tape port selector: auxiliary bus slave, controller poller, reload relay
`timescale 1ns/100ps
module tps_selector #(
  parameter logic [tps_pkg::UNIT_W-1:0] UNIT_CODE = tps_pkg::UNIT_DEFAULT  // Arbitrary value
) (
  input  wire logic                                clock,            // 250 MHz clock
  input  wire logic                                reset_n,          // Async reset, low
  // Auxiliary unit bus, central control accesses
  input  wire logic                                aub_req,          // Access held till ack
  input  wire logic                                aub_write,        // 1 write, 0 read
  input  wire logic [tps_pkg::ADDR_W-1:0]          aub_address,      // Mode, unit, target, index
  input  wire logic [tps_pkg::WORD_W-1:0]          aub_wdata,        // Write word
  output logic                                     aub_ack,          // One-cycle answer
  output logic      [tps_pkg::WORD_W-1:0]          aub_rdata,        // Read word
  // Auxiliary unit bus, store accesses toward bus interface
  output logic                                     sto_valid,        // Store word pending
  input  wire logic                                sto_ready,        // Bus interface takes it
  output logic                                     sto_write,        // Store write order
  output logic      [tps_pkg::WORD_W-1:0]          sto_address,      // Store address
  output logic      [tps_pkg::WORD_W-1:0]          sto_wdata,        // Store write data
  input  wire logic                                sto_reply_valid,  // Read word returned
  input  wire logic [tps_pkg::WORD_W-1:0]          sto_reply_data,   // Returned word
  output logic                                     interject_req,    // Relayed interject
  // Tape drive controller community
  input  wire logic [tps_pkg::NUM_CTRL-1:0]        tdc_store_req,    // Store access wanted
  input  wire logic [tps_pkg::NUM_CTRL-1:0]        tdc_interject,    // Interject requests
  input  wire logic [tps_pkg::NUM_CTRL-1:0]        tdc_error,        // Transfer error seen
  input  wire logic [tps_pkg::NUM_CTRL-1:0]        tdc_reload_ready, // Reload tape and role
  input  wire logic [tps_pkg::NUM_CTRL-1:0]        tdc_reload_run,   // Reload under way
  output logic      [tps_pkg::NUM_CTRL-1:0]        tdc_enable,       // One-hot store grant
  input  wire logic                                tdc_word_valid,   // Enabled ctrl word
  output logic                                     tdc_word_ready,   // Word accepted
  input  wire logic                                tdc_word_write,   // Word store order
  input  wire logic [tps_pkg::WORD_W-1:0]          tdc_word_addr,    // Word store address
  input  wire logic [tps_pkg::WORD_W-1:0]          tdc_word_data,    // Word write data
  output logic                                     tdc_reply_valid,  // Read word to ctrl
  output logic      [tps_pkg::WORD_W-1:0]          tdc_reply_data,   // Read word
  output logic                                     tdc_cmd_valid,    // Command handoff
  output logic      [tps_pkg::CTRL_IDX_W-1:0]      tdc_cmd_target,   // Addressed controller
  output logic      [tps_pkg::WORD_W-1:0]          tdc_cmd_word,     // Command register
  output logic      [tps_pkg::WORD_W-1:0]          tdc_cmd_addr,     // Address register
  output logic                                     reload_broadcast, // Reload to all ctrls
  // Maintenance logic
  input  wire logic                                reload_request,   // Reload demanded
  input  wire logic                                side_active,      // Our bus side active
  output logic                                     ready_for_reload, // Reload ready
  output logic                                     reload_active,    // Reload started
  output logic                                     reload_error      // Error during reload
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // The unit code is a parameter, so no bus write can ever reach it
  wire [tps_pkg::UNIT_W-1:0]     unit_field   = aub_address[tps_pkg::UNIT_HI:tps_pkg::UNIT_LO];
  wire                           unit_match   = (unit_field == UNIT_CODE);
  wire                           control_mode = aub_address[tps_pkg::MODE_BIT];
  wire                           to_ctrl      = aub_address[tps_pkg::TARGET_BIT];
  wire [tps_pkg::INDEX_W-1:0]    index        = aub_address[tps_pkg::INDEX_HI:0];
  wire [tps_pkg::CTRL_IDX_W-1:0] ctrl_index   = index[tps_pkg::CTRL_IDX_W-1:0];

  tps_pkg::tps_state_type        state;
  tps_pkg::tps_state_type        next_state;
  logic [tps_pkg::NUM_CTRL-1:0]  assign_set;
  logic [tps_pkg::WORD_W-1:0]    command_reg;
  logic [tps_pkg::WORD_W-1:0]    address_reg;
  logic [tps_pkg::CTRL_IDX_W-1:0] grant_idx;
  logic [tps_pkg::CTRL_IDX_W-1:0] last_idx;
  wire                            fifo_empty;

  // A hit is only taken while scanning, between controller grants
  wire cc_hit     = aub_req && unit_match && (state == tps_pkg::ST_SCAN);
  wire cc_write   = cc_hit && aub_write;
  wire norm_reg   = !control_mode && !to_ctrl;
  wire ctrl_reg   = control_mode && !to_ctrl;
  wire forward_go = cc_write && !control_mode && to_ctrl;

  // ****************************************************************
  // Controller eligibility and arbitration
  // ****************************************************************
  // Requests from controllers owned by the other selector are invisible
  wire [tps_pkg::NUM_CTRL-1:0] eligible = tdc_store_req & assign_set;
  wire                         arb_found;
  wire [tps_pkg::CTRL_IDX_W-1:0] arb_pick;

  tps_rr_arbiter u_arbiter (
    .req   (eligible),
    .last  (last_idx),
    .found (arb_found),
    .pick  (arb_pick)
  );

  wire grant_done = !eligible[grant_idx] || (tdc_error[grant_idx] && !reload_active);
  wire start_grant = !cc_hit && arb_found && !(aub_req && unit_match && control_mode);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Central control wins a scan slot; grants and accesses both return to scan
  always_comb begin
    next_state = state;
    case (state)
      tps_pkg::ST_SCAN: begin
        if (cc_hit) begin
          next_state = tps_pkg::ST_ACCESS;
        end else if (start_grant) begin
          next_state = tps_pkg::ST_GRANT;
        end
      end
      tps_pkg::ST_GRANT: begin
        if (grant_done) next_state = tps_pkg::ST_SCAN;
      end
      tps_pkg::ST_ACCESS: next_state = tps_pkg::ST_SCAN;
      default: next_state = tps_pkg::ST_SCAN;
    endcase
  end

  // State and grant bookkeeping
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state     <= tps_pkg::ST_SCAN;
      grant_idx <= '0;
      last_idx  <= '1;
    end else begin
      state <= next_state;
      if (state == tps_pkg::ST_SCAN && !cc_hit && start_grant) grant_idx <= arb_pick;
      if (state == tps_pkg::ST_GRANT && grant_done) last_idx <= grant_idx;
    end
  end

  // One-hot enable, only ever one controller at a time
  wire [tps_pkg::CTRL_IDX_W-1:0] enable_idx = (state == tps_pkg::ST_GRANT) ? grant_idx : arb_pick;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdc_enable <= '0;
    end else if (next_state == tps_pkg::ST_GRANT) begin
      tdc_enable <= tps_pkg::NUM_CTRL'(1) << enable_idx;
    end else begin
      tdc_enable <= '0;
    end
  end

  // ****************************************************************
  // Register file and central control answers
  // ****************************************************************
  // Both register views share the same two command words
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      assign_set  <= tps_pkg::ASSIGN_RESET;
      command_reg <= tps_pkg::WORD_RESET;
      address_reg <= tps_pkg::WORD_RESET;
    end else if (cc_write) begin
      if ((norm_reg && index == tps_pkg::REG_COMMAND) ||
          (ctrl_reg && index == tps_pkg::CREG_COMMAND)) command_reg <= aub_wdata;
      if ((norm_reg && index == tps_pkg::REG_ADDRESS) ||
          (ctrl_reg && index == tps_pkg::CREG_ADDRESS)) address_reg <= aub_wdata;
      if (ctrl_reg && index == tps_pkg::CREG_ASSIGN) begin
        assign_set <= aub_wdata[tps_pkg::NUM_CTRL-1:0];
      end
    end
  end

  // Status word seen through the control-mode view
  wire [tps_pkg::WORD_W-1:0] status_word = {14'h0000, reload_error, reload_active,
                                            ready_for_reload, interject_req,
                                            (state == tps_pkg::ST_GRANT), fifo_empty,
                                            grant_idx};

  // Read multiplexer; unmapped indexes and controller reads give zero
  logic [tps_pkg::WORD_W-1:0] read_word;
  always_comb begin
    read_word = '0;
    if (norm_reg && index == tps_pkg::REG_COMMAND) read_word = command_reg;
    if (norm_reg && index == tps_pkg::REG_ADDRESS) read_word = address_reg;
    if (ctrl_reg && index == tps_pkg::CREG_ASSIGN) read_word = {8'h00, assign_set};
    if (ctrl_reg && index == tps_pkg::CREG_STATUS) read_word = status_word;
    if (ctrl_reg && index == tps_pkg::CREG_COMMAND) read_word = command_reg;
    if (ctrl_reg && index == tps_pkg::CREG_ADDRESS) read_word = address_reg;
  end

  // Answer one cycle after the access is taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aub_ack   <= 1'b0;
      aub_rdata <= '0;
    end else begin
      aub_ack <= cc_hit;
      if (cc_hit && !aub_write) aub_rdata <= read_word;
    end
  end

  // Command handoff; afterwards the selector is free for others
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdc_cmd_valid  <= 1'b0;
      tdc_cmd_target <= '0;
      tdc_cmd_word   <= '0;
      tdc_cmd_addr   <= '0;
    end else begin
      tdc_cmd_valid <= forward_go;
      if (forward_go) begin
        tdc_cmd_target <= ctrl_index;
        tdc_cmd_word   <= command_reg;
        tdc_cmd_addr   <= address_reg;
      end
    end
  end

  // ****************************************************************
  // Store word path
  // ****************************************************************
  // Words pass only from the enabled controller; the FIFO stalls it
  wire                        fifo_in_valid = tdc_word_valid && (state == tps_pkg::ST_GRANT);
  wire                        fifo_in_ready;
  wire [tps_pkg::STORE_W-1:0] fifo_out;

  assign tdc_word_ready = fifo_in_ready && (state == tps_pkg::ST_GRANT);

  tps_fifo #(
    .WIDTH (tps_pkg::STORE_W),
    .DEPTH (tps_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({tdc_word_write, tdc_word_addr, tdc_word_data}),
    .out_valid (sto_valid),
    .out_ready (sto_ready),
    .out_data  (fifo_out),
    .empty     (fifo_empty)
  );

  // Field split of the queued store word
  assign sto_write   = fifo_out[tps_pkg::STORE_W-1];
  assign sto_address = fifo_out[2*tps_pkg::WORD_W-1:tps_pkg::WORD_W];
  assign sto_wdata   = fifo_out[tps_pkg::WORD_W-1:0];

  // Read replies go back to the controllers one word at a time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdc_reply_valid <= 1'b0;
      tdc_reply_data  <= '0;
    end else begin
      tdc_reply_valid <= sto_reply_valid;
      if (sto_reply_valid) tdc_reply_data <= sto_reply_data;
    end
  end

  // ****************************************************************
  // Interject relay and reload signalling
  // ****************************************************************
  // One bus side only, so no bus-select flip-flops exist here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      interject_req    <= 1'b0;
      ready_for_reload <= 1'b0;
      reload_broadcast <= 1'b0;
    end else begin
      interject_req    <= |(tdc_interject & assign_set);
      ready_for_reload <= |tdc_reload_ready;
      reload_broadcast <= reload_request && side_active;
    end
  end

  // Errors during reload are flagged, never abort the transfer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reload_active <= 1'b0;
      reload_error  <= 1'b0;
    end else if (!reload_broadcast) begin
      reload_active <= 1'b0;
      reload_error  <= 1'b0;
    end else begin
      if (|tdc_reload_run) reload_active <= 1'b1;
      if (reload_active && |tdc_error) reload_error <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_foreign_ignored;
    aub_req && !unit_match |=> !aub_ack;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("foreign access answered");

  property p_ack_needs_code;
    aub_ack |-> $past(aub_address[tps_pkg::UNIT_HI:tps_pkg::UNIT_LO]) == UNIT_CODE;
  endproperty
  a_ack_needs_code: assert property (p_ack_needs_code)
    else $error("ack with wrong unit code");

  property p_enable_assigned;
    (tdc_enable != '0) |-> ((tdc_enable & assign_set) == tdc_enable);
  endproperty
  a_enable_assigned: assert property (p_enable_assigned)
    else $error("unassigned controller enabled");

  property p_single_grant;
    $onehot0(tdc_enable);
  endproperty
  a_single_grant: assert property (p_single_grant)
    else $error("several controllers enabled");

  property p_forward;
    forward_go |=> tdc_cmd_valid && tdc_cmd_word == $past(command_reg)
                   && tdc_cmd_addr == $past(address_reg);
  endproperty
  a_forward: assert property (p_forward) else $error("command not forwarded");

  property p_control_no_grant;
    cc_hit && control_mode |=> tdc_enable == '0 ##1 tdc_enable == '0;
  endproperty
  a_control_no_grant: assert property (p_control_no_grant)
    else $error("grant in control mode");

  property p_interject;
    (tdc_interject & assign_set) != '0 |=> interject_req;
  endproperty
  a_interject: assert property (p_interject) else $error("interject not relayed");

  property p_broadcast;
    reload_request && side_active [*2] |-> reload_broadcast;
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("reload not broadcast");

  property p_reload_error;
    reload_active && reload_broadcast && (tdc_error != '0) |=> reload_error;
  endproperty
  a_reload_error: assert property (p_reload_error) else $error("reload error missed");

  property p_reload_keeps_grant;
    state == tps_pkg::ST_GRANT && reload_active && eligible[grant_idx]
      |=> state == tps_pkg::ST_GRANT;
  endproperty
  a_reload_keeps_grant: assert property (p_reload_keeps_grant)
    else $error("reload grant dropped");

  c_grant:   cover property (state == tps_pkg::ST_SCAN ##1 state == tps_pkg::ST_GRANT);
  c_forward: cover property (tdc_cmd_valid);
  c_reload:  cover property (reload_active ##1 reload_error);
  c_full:    cover property (!fifo_in_ready && tdc_word_valid);

endmodule // tps_selector

// ---- sim/tps_bus_model.sv ----
// Bus interface model that takes store words and answers reads
`timescale 1ns/100ps
module tps_bus_model (
  input  wire logic        clock,           // System clock
  input  wire logic        stall,           // Hold off acceptance
  input  wire logic        sto_valid,       // Word pending
  output logic             sto_ready,       // Word taken
  input  wire logic        sto_write,       // Store write order
  input  wire logic [23:0] sto_address,     // Store address
  output logic             sto_reply_valid, // Read reply pulse
  output logic      [23:0] sto_reply_data   // Read word
);
  // One word per handshake, so a stall can fill the buffer
  always @(posedge clock) begin
    sto_ready <= #1 !stall;
    sto_reply_valid <= #1 sto_valid && sto_ready && !sto_write;
    sto_reply_data <= #1 ~sto_address;
  end
endmodule // tps_bus_model

// ---- sim/tape_port_selector_test.sv ----
// Testbench of the tape port selector against a bench model
`timescale 1ns/100ps
module tape_port_selector_test;
  logic clock = 0, reset_n = 0, aub_req = 0, aub_write = 0, stall = 1, ok;
  logic tdc_word_valid = 0, tdc_word_write = 0, reload_request = 0, side_active = 0;
  logic sto_ready, sto_reply_valid, aub_ack, sto_valid, sto_write, interject_req;
  logic tdc_word_ready, tdc_reply_valid, tdc_cmd_valid, reload_broadcast;
  logic ready_for_reload, reload_active, reload_error;
  logic [16:0] aub_address = 0;
  logic [23:0] aub_wdata = 0, tdc_word_addr = 0, tdc_word_data = 0, lfsr = 24'h000050;
  logic [23:0] sto_reply_data, aub_rdata, sto_address, sto_wdata, tdc_reply_data;
  logic [23:0] tdc_cmd_word, tdc_cmd_addr, rd, cmd, adr;
  logic [15:0] tdc_store_req = 0, tdc_interject = 0, tdc_error = 0;
  logic [15:0] tdc_reload_ready = 0, tdc_reload_run = 0, tdc_enable;
  logic [3:0]  tdc_cmd_target;
  logic [28:0] cv;
  logic [48:0] q[$];
  logic [23:0] rq[$];
  int          miscompares = 0, compares = 0, n, k;
  tps_selector i_dut (.*);
  tps_bus_model i_bus (.*);
  always #2 clock = ~clock;
  // Bench random source
  function automatic logic [23:0] rnd();
    lfsr = {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
    return lfsr;
  endfunction
  task automatic cmp(input logic [48:0] got, input logic [48:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Request held until the acknowledge is seen, bounded wait
  task automatic acc(input logic w, input logic [16:0] a, input logic [23:0] d, input logic hit);
    aub_req = 1;
    aub_write = w;
    aub_address = a;
    aub_wdata = d;
    for (n = 0; n < 30 && aub_ack !== 1'b1; n++) @(posedge clock) #1;
    aub_req = 0;
    rd = aub_rdata;
    cv = {tdc_cmd_valid, tdc_cmd_target, tdc_cmd_word};
    cmp(aub_ack, hit);
    @(posedge clock) #1;
  endtask
  // Valid stays up between words; data only changes after acceptance
  task automatic put(output logic acc_ok);
    tdc_word_valid = 1;
    tdc_word_addr = rnd();
    tdc_word_write = lfsr[0];
    tdc_word_data = rnd();
    #2 acc_ok = tdc_word_ready;
    if (acc_ok) q.push_back({tdc_word_write, tdc_word_addr, tdc_word_data});
    @(posedge clock) #1;
  endtask
  // Bench model: words leave in order, reads come back as the inverted address
  always @(posedge clock) begin
    if (sto_valid && sto_ready && !sto_write) rq.push_back(~sto_address);
    if (sto_valid && sto_ready) cmp({sto_write, sto_address, sto_wdata}, q.pop_front());
    if (tdc_reply_valid) cmp(tdc_reply_data, rq.pop_front());
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 reset_n = 1;
    cmp(tdc_enable, 0);
    acc(1, {6'h23, 11'h000}, 24'h000005, 0);
    acc(1, {6'h22, 11'h000}, 24'h000005, 1);
    acc(0, {6'h22, 11'h000}, 0, 1);
    cmp(rd, 24'h000005);
    cmd = rnd();
    acc(1, {6'h02, 11'h000}, cmd, 1);
    acc(0, {6'h02, 11'h000}, 0, 1);
    cmp(rd, cmd);
    adr = rnd();
    acc(1, {6'h02, 11'h001}, adr, 1);
    acc(1, {6'h02, 11'h402}, 0, 1);
    cmp(cv, {5'h12, cmd});
    cmp(tdc_cmd_addr, adr);
    acc(0, {6'h22, 11'h003}, 0, 1);
    cmp(rd, adr);
    acc(0, {6'h22, 11'h3FF}, 0, 1);
    cmp(rd, 0);
    $display("register test done");
    tdc_store_req = 16'h0006;
    for (n = 0; n < 20 && tdc_enable === 0; n++) @(posedge clock) #1;
    cmp(tdc_enable, 16'h0004);
    ok = 1;
    for (k = 0; ok && k < 40; k += ok) put(ok);
    tdc_word_valid = 0;
    cmp(k, 32);
    stall = 0;
    for (n = 0; n < 100 && q.size() > 0; n++) @(posedge clock) #1;
    cmp(q.size(), 0);
    // Error outside reload ends grant 2; the next turn skips past it to 0
    tdc_store_req = 16'h0005;
    tdc_error = 16'h0004;
    for (n = 0; n < 20 && tdc_enable !== 16'h0001; n++) @(posedge clock) #1;
    cmp(tdc_enable, 16'h0001);
    tdc_store_req = 0;
    tdc_error = 0;
    repeat (3) @(posedge clock) #1;
    cmp(tdc_enable, 0);
    cmp(rq.size(), 0);
    acc(0, {6'h22, 11'h001}, 0, 1);
    cmp(rd, 24'h000010);
    $display("store test done");
    tdc_interject = 16'h0002;
    repeat (3) @(posedge clock) #1;
    cmp(interject_req, 0);
    tdc_interject = 16'h0006;
    repeat (3) @(posedge clock) #1;
    cmp(interject_req, 1);
    $display("interject test done");
    tdc_store_req = 16'h0004;
    tdc_reload_ready = 16'h0008;
    tdc_reload_run = 16'h0008;
    tdc_error = 16'h0008;
    reload_request = 1;
    side_active = 1;
    repeat (4) @(posedge clock) #1;
    cmp({ready_for_reload, reload_broadcast}, 2'h3);
    cmp({reload_active, reload_error}, 2'h3);
    tdc_error = 16'h000C;
    repeat (2) @(posedge clock) #1;
    cmp(tdc_enable, 16'h0004);
    $display("reload test done");
    stop_test();
  end
endmodule // tape_port_selector_test
